// >>> logic/wdm_datapath.sv
// Width control, byte mask, pattern load and bank-set steering data path
//
// Notes on behaviour
// RULE1: at x16 each core word goes to its own pin, sixteen bit slots
// RULE2: narrower widths use fewer pins; sub-column selects the core words read
// RULE3: x4 ignores sub-column bits 1:0; bits 3:2 pick a 64-bit block, pins 3:0
// RULE4: sub-column is the low extension of the column address, decoded together
// RULE5: at x16 each core word is filled from its own pin
// RULE6: writes map pins onto core words by width and sub-column, mirroring reads
// RULE7: only x16, x8 and x4 widths exist
// RULE8: masked writes treat data as 32 bytes gated by an eight-bit mask
// RULE9: byte not equal to mask is written, equal byte is left alone
// RULE10: controller picks a mask value unused by all data bytes
// RULE11: masked writes follow ordinary write packet timing
// RULE12: each pin carries two bytes, byte 0 first, bit 0 first
// RULE13: serial byte bits map onto core bits in the fixed interleave
// RULE14: each pin sends core bits D0 to D15 in ascending slots
// RULE15: pattern words 0 to 15 land in the fixed core word order
// RULE16: pattern writes store words selected by width and sub-column bits
// RULE17: each pattern byte shifts the holding register by eight
// RULE18: bank address bit 0 picks even or odd bank set
// RULE19: each bank set has its own core bus, reachable for reads and writes
// RULE20: controller spaces write-to-read by the bank-set minimum
// RULE21: unsupported width codes move no data
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module wdm_datapath
    import wdm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pattern load pins
    input wire logic request_clock,
    input wire logic serial_pattern_frame,
    input wire logic serial_pattern_load,
    // Column requests and pin-side data
    input wire wdm_pkg::wdm_col_req_t col_req,
    input wire logic [255:0] write_bus,
    output logic [255:0] read_bus,
    // Core buses
    input wire logic [255:0] even_set_rd,
    input wire logic [255:0] odd_set_rd,
    output wdm_pkg::wdm_core_wr_t even_set_data_bus,
    output wdm_pkg::wdm_core_wr_t odd_set_data_bus
);
    import wdm_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_STAGES-1:0] sync_clk, sync_frm, sync_dat;
    logic clk_lvl, frm_lvl, dat_lvl, next_clk_lvl, next_frm_lvl, next_dat_lvl;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_clk <= '0;
            sync_frm <= '0;
            sync_dat <= '0;
        end else if (ce) begin
            sync_clk <= {sync_clk[1:0], request_clock};
            sync_frm <= {sync_frm[1:0], serial_pattern_frame};
            sync_dat <= {sync_dat[1:0], serial_pattern_load};
        end
    end
    // A change is accepted only once stages two and three agree
    always_comb begin
        next_clk_lvl = (sync_clk[1] == sync_clk[2]) ? sync_clk[2] : clk_lvl;
        next_frm_lvl = (sync_frm[1] == sync_frm[2]) ? sync_frm[2] : frm_lvl;
        next_dat_lvl = (sync_dat[1] == sync_dat[2]) ? sync_dat[2] : dat_lvl;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_lvl <= 1'b0;
            frm_lvl <= 1'b0;
            dat_lvl <= 1'b0;
        end else if (ce) begin
            clk_lvl <= next_clk_lvl;
            frm_lvl <= next_frm_lvl;
            dat_lvl <= next_dat_lvl;
        end
    end
    logic rc_rise;
    assign rc_rise = next_clk_lvl & ~clk_lvl;

    // ==========================================================
    // Serial pattern shifter and holding register
    logic [7:0] ser_byte, next_ser_byte;
    logic [2:0] ser_cnt, next_ser_cnt;
    logic [255:0] hold, next_hold;
    logic [7:0] loads, next_loads;
    logic push, hold_clr;
    always_comb begin
        next_ser_byte = ser_byte;
        next_ser_cnt = ser_cnt;
        next_hold = hold;
        next_loads = loads;
        push = 1'b0;
        if (!frm_lvl) begin
            next_ser_cnt = 3'h0;
        end else if (rc_rise) begin
            // Serial field bit 7 arrives first
            next_ser_byte = {ser_byte[6:0], dat_lvl};
            next_ser_cnt = ser_cnt + 3'h1;
            if (ser_cnt == 3'h7) begin
                push = 1'b1;
            end
        end
        // RULE17 shift by eight
        if (push) begin
            next_hold = {hold[247:0], ser_byte[6:0], dat_lvl};
            next_loads = loads + 8'h01;
        end else if (hold_clr) begin
            next_loads = LOADS_RST;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ser_byte <= '0;
            ser_cnt <= '0;
            hold <= '0;
            loads <= LOADS_RST;
        end else if (ce) begin
            ser_byte <= next_ser_byte;
            ser_cnt <= next_ser_cnt;
            hold <= next_hold;
            loads <= next_loads;
        end
    end
    // Oldest byte sits at the top once a full column of 32 bytes is loaded
    logic [15:0] pat_core [16];
    always_comb begin
        for (int w = 0; w < WORDS; w++) begin
            pat_core[w] = '0;
        end
        // RULE13 RULE15 unscramble
        for (int n = 0; n < WORDS; n++) begin
            for (int k = 0; k < WBITS; k++) begin
                pat_core[LOAD_TO_CORE[n]][BIT_MAP[k]] = hold[(31 - 2*n - k/8)*8 + k%8];
            end
        end
    end

    // ==========================================================
    // APB slave: one wait state, unmapped answers with pslverr
    logic [2:0] width, next_width;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, acc, bad_width;
    assign acc = psel & penable & ~pready;
    // RULE7 RULE21 only three codes supported
    assign bad_width = (width != WIDTH_X16) && (width != WIDTH_X8) && (width != WIDTH_X4);
    always_comb begin
        next_width = width;
        next_prdata = 32'h0;
        next_pready = acc;
        next_pslverr = 1'b0;
        hold_clr = 1'b0;
        if (acc) begin
            unique case (paddr)
                ADDR_CFG: begin
                    next_prdata[CFG_WIDTH_LSB +: 3] = width;
                    if (pwrite) begin
                        next_width = pwdata[CFG_WIDTH_LSB +: 3];
                    end
                end
                ADDR_STAT: begin
                    next_prdata[STAT_LOADS_LSB +: 8] = loads;
                    next_prdata[STAT_BADW_BIT] = bad_width;
                end
                ADDR_HOLD_CLR: begin
                    hold_clr = pwrite;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            width <= CFG_RST;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            width <= next_width;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Column path: width mapping, masking, bank-set steering
    logic [15:0] word_en;
    logic [255:0] core_wdata, rd_core, next_read_bus;
    logic [31:0] byte_ne, byte_we;
    wdm_core_wr_t next_even, next_odd, wr_pkt;
    always_comb begin
        word_en = '0;
        core_wdata = '0;
        next_read_bus = read_bus;
        // RULE18 RULE19 set chosen by bank bit 0
        rd_core = col_req.bank[0] ? odd_set_rd : even_set_rd;
        for (int w = 0; w < WORDS; w++) begin
            // RULE5 RULE6 RULE16 pin to core word map
            unique case (width)
                WIDTH_X16: begin
                    word_en[w] = 1'b1;
                    core_wdata[w*16 +: 16] = write_bus[w*16 +: 16];
                end
                WIDTH_X8: begin
                    word_en[w] = (w/8 == int'(col_req.subcolumn[3]));
                    core_wdata[w*16 +: 16] = write_bus[(w%8)*16 +: 16];
                end
                WIDTH_X4: begin
                    // RULE3 sub-column bits 1:0 unused
                    word_en[w] = (w/4 == int'(col_req.subcolumn[3:2]));
                    core_wdata[w*16 +: 16] = write_bus[(w%4)*16 +: 16];
                end
                default: begin
                    word_en[w] = 1'b0;
                end
            endcase
            if (col_req.pattern) begin
                core_wdata[w*16 +: 16] = pat_core[w];
            end
        end
        if (col_req.valid && !col_req.write) begin
            next_read_bus = '0;
            for (int p = 0; p < WORDS; p++) begin
                // RULE1 RULE2 core word to pin map
                unique case (width)
                    WIDTH_X16: next_read_bus[p*16 +: 16] = rd_core[p*16 +: 16];
                    WIDTH_X8: begin
                        if (p < 8) begin
                            next_read_bus[p*16 +: 16] =
                                rd_core[(8*int'(col_req.subcolumn[3]) + p)*16 +: 16];
                        end
                    end
                    WIDTH_X4: begin
                        if (p < 4) begin
                            next_read_bus[p*16 +: 16] =
                                rd_core[(4*int'(col_req.subcolumn[3:2]) + p)*16 +: 16];
                        end
                    end
                    default: next_read_bus[p*16 +: 16] = 16'h0;
                endcase
            end
        end
        for (int b = 0; b < BYTES; b++) begin
            // RULE8 RULE9 masked byte gating
            byte_we[b] = word_en[b/2] & (~col_req.masked | byte_ne[b]);
        end
        // RULE11 same write timing
        wr_pkt.write = col_req.valid & col_req.write;
        wr_pkt.bank = col_req.bank;
        // RULE4 column plus sub-column address
        wr_pkt.col_addr = {col_req.column, col_req.subcolumn};
        wr_pkt.byte_we = wr_pkt.write ? byte_we : 32'h0;
        wr_pkt.data = core_wdata;
        next_even = '0;
        next_odd = '0;
        if (col_req.bank[0]) begin
            next_odd = wr_pkt;
        end else begin
            next_even = wr_pkt;
        end
    end
    wdm_byte_mask #(
        .BYTES(BYTES)
    ) u_mask (
        .data(core_wdata),
        .mask(col_req.mask),
        .byte_ne(byte_ne)
    );
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            read_bus <= '0;
            even_set_data_bus <= '0;
            odd_set_data_bus <= '0;
        end else if (ce) begin
            read_bus <= next_read_bus;
            even_set_data_bus <= next_even;
            odd_set_data_bus <= next_odd;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_rd(logic [2:0] wc);
        ce && col_req.valid && !col_req.write && width == wc;
    endsequence
    sequence s_wr(logic [2:0] wc);
        ce && col_req.valid && col_req.write && width == wc;
    endsequence
    property p_rd_x16;
        s_rd(WIDTH_X16) |=> read_bus
            == ($past(col_req.bank[0]) ? $past(odd_set_rd) : $past(even_set_rd));
    endproperty
    a_rd_x16: assert property (p_rd_x16) else $error("x16 read map wrong"); // RULE1
    property p_rd_x4;
        s_rd(WIDTH_X4) ##0 col_req.bank[0] |=> read_bus[255:64] == '0
            && read_bus[63:0] == $past(odd_set_rd[{col_req.subcolumn[3:2], 6'h00} +: 64]);
    endproperty
    a_rd_x4: assert property (p_rd_x4) else $error("x4 read block wrong"); // RULE3
    property p_wr_x16;
        s_wr(WIDTH_X16) ##0 (!col_req.masked && !col_req.bank[0])
            |=> even_set_data_bus.byte_we == 32'hFFFFFFFF && odd_set_data_bus.byte_we == '0;
    endproperty
    a_wr_x16: assert property (p_wr_x16) else $error("x16 write enables wrong"); // RULE5
    property p_wr_x8;
        s_wr(WIDTH_X8) ##0 (!col_req.masked && col_req.subcolumn[3])
            |=> (odd_set_data_bus.byte_we | even_set_data_bus.byte_we) == 32'hFFFF0000;
    endproperty
    a_wr_x8: assert property (p_wr_x8) else $error("x8 word select wrong"); // RULE16
    property p_mask_skip;
        s_wr(WIDTH_X16) ##0 (col_req.masked && !col_req.pattern && write_bus[7:0] == col_req.mask)
            |=> !(even_set_data_bus.byte_we[0] | odd_set_data_bus.byte_we[0]);
    endproperty
    a_mask_skip: assert property (p_mask_skip) else $error("masked byte written"); // RULE9
    property p_unsup;
        ce && col_req.valid && bad_width |=> even_set_data_bus.byte_we == '0
            && odd_set_data_bus.byte_we == '0 ##1 1'b1;
    endproperty
    a_unsup: assert property (p_unsup) else $error("unsupported width wrote"); // RULE21
    property p_set;
        ce && col_req.valid && col_req.write && col_req.bank[0] |=> even_set_data_bus == '0
            && odd_set_data_bus.bank == $past(col_req.bank);
    endproperty
    a_set: assert property (p_set) else $error("wrong bank set driven"); // RULE18
    property p_shift;
        ce && push |=> hold[255:8] == $past(hold[247:0]) && loads == $past(loads) + 8'h01;
    endproperty
    a_shift: assert property (p_shift) else $error("pattern shift wrong"); // RULE17
endmodule

// >>> logic/wdm_pkg.sv
// Constants and carrier types shared by the width and mask data path
package wdm_pkg;
    // ==========================================================
    // Geometry
    localparam int WORDS = 16;
    localparam int WBITS = 16;
    localparam int CORE_W = 256;
    localparam int BYTES = 32;
    localparam int SER_BITS = 8;
    localparam int SYNC_STAGES = 3;
    // ==========================================================
    // Width configuration codes
    localparam logic [2:0] WIDTH_X16 = 3'h0;
    localparam logic [2:0] WIDTH_X8 = 3'h1;
    localparam logic [2:0] WIDTH_X4 = 3'h2;
    localparam logic [2:0] CFG_RST = WIDTH_X16;
    // ==========================================================
    // Register map and fields
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_HOLD_CLR = 8'h08;
    localparam int CFG_WIDTH_LSB = 0;
    localparam int STAT_LOADS_LSB = 0;
    localparam int STAT_BADW_BIT = 8;
    localparam logic [7:0] LOADS_RST = 8'h00;
    // ==========================================================
    // Pattern load order: load word n lands in core word LOAD_TO_CORE[n]
    localparam logic [3:0] LOAD_TO_CORE [16] = '{4'hF, 4'h7, 4'hB, 4'h3, 4'hD, 4'h5, 4'h9,
        4'h1, 4'hE, 4'h6, 4'hA, 4'h2, 4'hC, 4'h4, 4'h8, 4'h0};
    // Index {byte, bit}: core bit carried by that serial bit
    localparam logic [3:0] BIT_MAP [16] = '{4'h2, 4'h6, 4'hA, 4'hE, 4'h3, 4'h7, 4'hB, 4'hF,
        4'h0, 4'h4, 4'h8, 4'hC, 4'h1, 4'h5, 4'h9, 4'hD};
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic write;
        logic masked;
        logic pattern;
        logic [2:0] bank;
        logic [5:0] column;
        logic [3:0] subcolumn;
        logic [7:0] mask;
    } wdm_col_req_t;
    typedef struct packed {
        logic write;
        logic [2:0] bank;
        logic [9:0] col_addr;
        logic [31:0] byte_we;
        logic [255:0] data;
    } wdm_core_wr_t;
endpackage

// >>> logic/wdm_byte_mask.sv
// Byte compare against the write mask value
`timescale 1ns/1ps
module wdm_byte_mask #(
    parameter int BYTES = 32
) (
    // Data and mask
    input wire logic [BYTES*8-1:0] data,
    input wire logic [7:0] mask,
    // Per-byte enable
    output logic [BYTES-1:0] byte_ne
);
    // ==========================================================
    // Compare
    genvar i;
    generate
        for (i = 0; i < BYTES; i++) begin : g_byte
            // RULE12 RULE14 byte i is bits i*8, bit 0 first
            assign byte_ne[i] = (data[i*8 +: 8] != mask);
        end
    endgenerate
endmodule

// >>> testbench/wdm_ctl_model.sv
// Controller model that shifts pattern bytes in over the request clock
`timescale 1ns/1ps
module wdm_ctl_model (
    // Serial pattern load pins
    output logic request_clock,
    output logic serial_pattern_frame,
    output logic serial_pattern_load
);
    // ==========================================================
    // Idle pins; the request clock stands still outside frames
    initial begin
        request_clock = 1'b0;
        serial_pattern_frame = 1'b0;
        serial_pattern_load = 1'b0;
    end
    // ==========================================================
    // One column as 32 bytes, byte k = col[k*8 +: 8]
    task automatic load_column(input logic [255:0] col);
        #7;
        serial_pattern_frame = 1'b1;
        for (int k = 0; k < 32; k++) begin
            for (int i = 7; i >= 0; i--) begin
                serial_pattern_load = col[k*8+i];
                #160;
                request_clock = 1'b1;
                #160;
                request_clock = 1'b0;
            end
        end
        // Let the last edge clear the synchroniser before closing
        #160;
        serial_pattern_frame = 1'b0;
        // Released line shows the inverse so a stale level cannot pass
        serial_pattern_load = ~serial_pattern_load;
    endtask
endmodule

// >>> testbench/tb_wdm_datapath.sv
// Self-checking bench for the width and mask data path
`timescale 1ns/1ps
module tb_wdm_datapath;
    import wdm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n, ce, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv, we;
    logic request_clock, serial_pattern_frame, serial_pattern_load;
    wdm_col_req_t col_req;
    logic [255:0] write_bus, read_bus, even_set_rd, odd_set_rd, colv, d, bm;
    wdm_core_wr_t even_set_data_bus, odd_set_data_bus;
    int n_errors = 0;
    int checked = 0;
    localparam logic [2:0] WC [7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2};
    localparam logic [3:0] SCV [7] = '{4'h5, 4'h3, 4'hB, 4'h3, 4'h6, 4'h9, 4'hF};
    localparam int ORD [16] = '{15, 7, 11, 3, 13, 5, 9, 1, 14, 6, 10, 2, 12, 4, 8, 0};

    always #20 clk_sys = ~clk_sys;

    wdm_datapath wdm_datapath_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .request_clock(request_clock),
        .serial_pattern_frame(serial_pattern_frame), .serial_pattern_load(serial_pattern_load),
        .col_req(col_req), .write_bus(write_bus), .read_bus(read_bus),
        .even_set_rd(even_set_rd), .odd_set_rd(odd_set_rd),
        .even_set_data_bus(even_set_data_bus), .odd_set_data_bus(odd_set_data_bus));
    wdm_ctl_model wdm_ctl_model_i (.request_clock(request_clock),
        .serial_pattern_frame(serial_pattern_frame), .serial_pattern_load(serial_pattern_load));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic colgo(input wdm_col_req_t r, input logic [255:0] w);
        @(posedge clk_sys);
        col_req <= r;
        write_bus <= w;
    endtask

    task automatic col(input wdm_col_req_t r, input logic [255:0] w);
        colgo(r, w);
        colgo('0, w);
        #1;
    endtask

    function automatic wdm_col_req_t rq(logic wr, logic m, logic p, logic [2:0] bk,
        logic [3:0] sc, logic [7:0] mk);
        rq = '{valid: 1'b1, write: wr, masked: m, pattern: p, bank: bk, column: 6'h2A,
            subcolumn: sc, mask: mk};
    endfunction

    // Words selected by width and sub-column: n pins from core word base
    task automatic sel(input logic [2:0] wc, input logic [3:0] sc, output int n, output int base);
        n = (wc == WIDTH_X16) ? 16 : (wc == WIDTH_X8) ? 8 : 4;
        base = (n == 16) ? 0 : (n == 8) ? 8 * sc[3] : 4 * sc[3:2];
        bm = '0;
        we = '0;
        for (int p = 0; p < n; p++) begin
            bm[(base+p)*16 +: 16] = 16'hFFFF;
            we[(base+p)*2 +: 2] = 2'b11;
        end
    endtask

    // Controller picks a byte value absent from the data
    function automatic logic [7:0] free_mask(input logic [255:0] w);
        logic [255:0] used;
        used = '0;
        for (int b = 0; b < 32; b++) used[w[b*8 +: 8]] = 1'b1;
        for (int v = 255; v >= 0; v--) if (!used[v]) free_mask = v[7:0];
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        apb(1'b0, ADDR_CFG, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({e, rdv}, 33'h100000000);
        for (int c = 3; c < 8; c += 4) begin
            apb(1'b1, ADDR_CFG, 32'(c));
            apb(1'b0, ADDR_STAT, 32'h0);
            chk(rdv[STAT_BADW_BIT], 1'b1);
            col(rq(1'b1, 1'b0, 1'b0, 3'h0, 4'h0, 8'h00), {8{32'hA5A5_5A5A}});
            chk(even_set_data_bus.byte_we, 32'h0);
            col(rq(1'b0, 1'b0, 1'b0, 3'h0, 4'h0, 8'h00), '0);
            chk(read_bus, '0);
        end
        // A frozen block must not launch the write pulse
        @(posedge clk_sys);
        ce <= 1'b0;
        col(rq(1'b1, 1'b0, 1'b0, 3'h0, 4'h0, 8'h00), '0);
        chk(even_set_data_bus.write, 1'b0);
        @(posedge clk_sys);
        ce <= 1'b1;
        $display("test regs done");
    endtask

    task automatic t_width;
        int n;
        int base;
        for (int t = 0; t < 7; t++) begin
            apb(1'b1, ADDR_CFG, {29'h0, WC[t]});
            sel(WC[t], SCV[t], n, base);
            colv = {8{32'h1357_9BDF + 32'(t)}} ^ {16{16'(t * 16'h0F31)}};
            d = '0;
            for (int p = 0; p < n; p++) d[(base+p)*16 +: 16] = colv[p*16 +: 16];
            col(rq(1'b1, 1'b0, 1'b0, 3'h2, SCV[t], 8'h00), colv);
            chk(even_set_data_bus.write, 1'b1);
            chk(odd_set_data_bus.write, 1'b0);
            chk(even_set_data_bus.byte_we, we);
            chk(even_set_data_bus.data & bm, d);
            chk(even_set_data_bus.col_addr, {6'h2A, SCV[t]});
            @(posedge clk_sys);
            odd_set_rd <= ~colv;
            even_set_rd <= colv;
            d = '0;
            for (int p = 0; p < n; p++) d[p*16 +: 16] = ~colv[(base+p)*16 +: 16];
            // read after write to the other set
            col(rq(1'b0, 1'b0, 1'b0, 3'h3, SCV[t], 8'h00), colv);
            chk(read_bus, d);
        end
        $display("test width done");
    endtask

    task automatic t_mask;
        logic [255:0] w2;
        logic [7:0] m2;
        apb(1'b1, ADDR_CFG, 32'h0);
        colv = {8{32'hC3C3_2468}} ^ {2{128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF}};
        w2 = colv;
        m2 = colv[7:0];
        colgo(rq(1'b1, 1'b1, 1'b0, 3'h4, 4'h0, free_mask(colv)), colv);
        colgo(rq(1'b1, 1'b1, 1'b0, 3'h5, 4'h0, m2), w2);
        #1;
        chk(even_set_data_bus.byte_we, 32'hFFFF_FFFF);
        chk(even_set_data_bus.data, colv);
        colgo('0, w2);
        #1;
        bm = '0;
        we = '0;
        for (int b = 0; b < 32; b++) begin
            we[b] = w2[b*8 +: 8] != m2;
            bm[b*8 +: 8] = {8{we[b]}};
        end
        chk(odd_set_data_bus.byte_we, we);
        chk(odd_set_data_bus.data & bm, w2 & bm);
        $display("test mask done");
    endtask

    task automatic t_pattern;
        int n;
        int base;
        for (int k = 0; k < 32; k++) colv[k*8 +: 8] = 8'(k * 29 + 53);
        wdm_ctl_model_i.load_column(colv);
        repeat (10) @(posedge clk_sys);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rdv[7:0], 8'h20);
        d = '0;
        for (int w = 0; w < 16; w++) begin
            for (int j = 0; j < 16; j++) begin
                d[ORD[w]*16 + 4*(j%8%4) + (j%8 >= 4 ? 3 : 2) - 2*(j/8)] = colv[(2*w+j/8)*8 + j%8];
            end
        end
        for (int t = 0; t < 3; t++) begin
            apb(1'b1, ADDR_CFG, {29'h0, WC[t*3%7]});
            sel(WC[t*3%7], SCV[t*3%7], n, base);
            col(rq(1'b1, 1'b0, 1'b1, 3'h6, SCV[t*3%7], 8'h00), ~colv);
            chk(even_set_data_bus.byte_we, we);
            chk(even_set_data_bus.data & bm, d & bm);
        end
        apb(1'b1, ADDR_HOLD_CLR, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rdv[7:0], 8'h00);
        $display("test pattern done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        col_req = '0;
        write_bus = '0;
        even_set_rd = '0;
        odd_set_rd = '0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_width();
        t_mask();
        t_pattern();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        stop_test();
    end
endmodule
